/* File: verilog/deflection_switch_register_port.sv */
// Write-only serial slave port and control switch registers
// Contract
// - Start, address 8C, subaddress, data, each acknowledged
// - Acknowledge each byte, never during power-on reset
// - Extra data bytes rewrite the same subaddress
// - Accept clock rates up to fast mode
// - Subaddress 01 D0 excludes unlock blanking
// - D1, D2 disable pin balance, parallelogram waves
// - D3 inhibits vertical oscillator gain control
// - D4 centres linearity and corner correction
// - D5 disables horizontal and vertical moire cancel
// - D6 selects television mode at minimum frequency
// - Subaddress 0B D0 makes EW track frequency
// - D2 selects enlarged overscan vertical size
// - D3 puts clamp on leading edge
// - D4 selects long vertical blanking pulse
// - D5 centres linearity balance adjustment
// - D6 centres position and trapezium adjustments
// - D7 connects auxiliary sawtooth to second loop
// - Subaddress 0D D0 disables internal supply
// - D1 releases soft start when set
// - Protection forces power bits to start values
// - After power-on reset: standby, soft start held
// - Writes take effect at once
`timescale 1ns/1ps
module deflection_switch_register_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  output logic sda_value,
  output logic sda_enable,
  input wire logic por_active,
  input wire logic protection_trip,
  output logic unlock_blank_exclude,
  output logic pin_balance_wave_disable,
  output logic parallelogram_wave_disable,
  output logic oscillator_gain_loop_inhibit,
  output logic linearity_corner_centre_force,
  output logic moire_cancel_disable,
  output logic television_fmin_select,
  output logic ew_line_tracking,
  output logic overscan_size_select,
  output logic clamp_leading_edge,
  output logic blank_duration_select,
  output logic linearity_balance_centre_force,
  output logic position_trapezium_centre_force,
  output logic sawtooth_link_connect,
  output logic power_down_bit,
  output logic gentle_startup_release
);
  import switch_port_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_q1;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // Line conditions
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;

  bus_condition_detect line_watch (
    .clk(clk),
    .rst_n(rst_n),
    .scl(scl),
    .sda(sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_level(sda_level)
  );

  // ----------------------------------------------------------------
  // Byte receiver
  // ----------------------------------------------------------------
  rx_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] sub_sel;
  logic [7:0] blanking_geometry_switches;
  logic [7:0] waveform_timing_switches;
  logic [1:0] power_startup_switches;
  logic in_byte;
  logic byte_done;
  logic byte_ack;
  logic data_write;

  // Byte phase decode and acknowledge decision
  assign in_byte = (state == st_addr) || (state == st_sub) || (state == st_data);
  assign byte_done = in_byte && scl_fall && (bit_cnt == BYTE_BITS);
  assign byte_ack = !por_active && ((state != st_addr) || (shift == CHIP_BUS_ADDRESS));
  assign data_write = (state == st_data) && byte_done && byte_ack;

  // Protocol sequencer; the data line is only pulled low in acknowledge slots
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      bit_cnt <= BIT_COUNT_ZERO;
      shift <= SWITCH_CLEAR;
      sda_enable <= 1'b0;
    end else if (stop_seen) begin
      state <= st_idle;
      bit_cnt <= BIT_COUNT_ZERO;
      sda_enable <= 1'b0;
    end else if (start_seen) begin
      state <= st_addr;
      bit_cnt <= BIT_COUNT_ZERO;
      sda_enable <= 1'b0;
    end else begin
      case (state)
        st_addr, st_sub, st_data: begin
          if (scl_rise && (bit_cnt != BYTE_BITS)) begin
            shift <= {shift[6:0], sda_level};
            bit_cnt <= bit_cnt + BIT_COUNT_STEP;
          end else if (byte_done) begin
            bit_cnt <= BIT_COUNT_ZERO;
            sda_enable <= byte_ack;
            if (!byte_ack) begin
              state <= st_idle;
            end else if (state == st_addr) begin
              state <= st_addr_ack;
            end else if (state == st_sub) begin
              state <= st_sub_ack;
            end else begin
              state <= st_data_ack;
            end
          end
        end
        st_addr_ack: begin
          if (scl_fall) begin
            sda_enable <= 1'b0;
            state <= st_sub;
          end
        end
        st_sub_ack: begin
          if (scl_fall) begin
            sda_enable <= 1'b0;
            state <= st_data;
          end
        end
        st_data_ack: begin
          if (scl_fall) begin
            sda_enable <= 1'b0;
            state <= st_data;
          end
        end
        default: begin
          state <= st_idle;
          sda_enable <= 1'b0;
        end
      endcase
    end
  end

  // Data line value is always low; only the enable moves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_value <= 1'b0;
    end else begin
      sda_value <= 1'b0;
    end
  end

  // Subaddress is taken once per transfer and never advanced
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_sel <= SWITCH_CLEAR;
    end else if ((state == st_sub) && byte_done && byte_ack) begin
      sub_sel <= shift;
    end
  end

  // ----------------------------------------------------------------
  // Switch registers
  // ----------------------------------------------------------------
  // Blanking and geometry switches, updated at the data byte's last bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blanking_geometry_switches <= SWITCH_CLEAR;
    end else if (data_write && (sub_sel == SUB_BLANK_GEOMETRY)) begin
      blanking_geometry_switches <= shift;
    end
  end

  // Waveform and timing switches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waveform_timing_switches <= SWITCH_CLEAR;
    end else if (data_write && (sub_sel == SUB_WAVE_TIMING)) begin
      waveform_timing_switches <= shift;
    end
  end

  // Power and start-up switches; protection overrides any host write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_startup_switches[POWER_DOWN_POS] <= POWER_DOWN_START;
      power_startup_switches[STARTUP_POS] <= STARTUP_START;
    end else if (protection_trip) begin
      power_startup_switches[POWER_DOWN_POS] <= POWER_DOWN_START;
      power_startup_switches[STARTUP_POS] <= STARTUP_START;
    end else if (data_write && (sub_sel == SUB_POWER_STARTUP)) begin
      power_startup_switches[POWER_DOWN_POS] <= shift[POWER_DOWN_POS];
      power_startup_switches[STARTUP_POS] <= shift[STARTUP_POS];
    end
  end

  // Other subaddresses match no register above and leave all unchanged

  // ----------------------------------------------------------------
  // Switch outputs, each a register bit; ignored bits go nowhere
  // ----------------------------------------------------------------
  assign unlock_blank_exclude = blanking_geometry_switches[UNLOCK_BLANK_POS];
  assign pin_balance_wave_disable = blanking_geometry_switches[PIN_BALANCE_POS];
  assign parallelogram_wave_disable = blanking_geometry_switches[PARALLELOGRAM_POS];
  assign oscillator_gain_loop_inhibit = blanking_geometry_switches[GAIN_INHIBIT_POS];
  assign linearity_corner_centre_force = blanking_geometry_switches[LIN_CORNER_POS];
  assign moire_cancel_disable = blanking_geometry_switches[MOIRE_POS];
  assign television_fmin_select = blanking_geometry_switches[TELEVISION_POS];
  assign ew_line_tracking = waveform_timing_switches[EW_TRACK_POS];
  assign overscan_size_select = waveform_timing_switches[OVERSCAN_POS];
  assign clamp_leading_edge = waveform_timing_switches[CLAMP_EDGE_POS];
  assign blank_duration_select = waveform_timing_switches[BLANK_LEN_POS];
  assign linearity_balance_centre_force = waveform_timing_switches[LIN_BALANCE_POS];
  assign position_trapezium_centre_force = waveform_timing_switches[POS_TRAP_POS];
  assign sawtooth_link_connect = waveform_timing_switches[SAW_LINK_POS];
  assign power_down_bit = power_startup_switches[POWER_DOWN_POS];
  assign gentle_startup_release = power_startup_switches[STARTUP_POS];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic mapped_sub;
  assign mapped_sub = (sub_sel == SUB_BLANK_GEOMETRY) || (sub_sel == SUB_WAVE_TIMING) ||
    (sub_sel == SUB_POWER_STARTUP);

  por_no_ack_a: assert property (
    (byte_done && por_active) |=> !sda_enable && (state == st_idle))
    else $error("acknowledge driven during power-on reset");

  addr_match_ack_a: assert property (
    (state == st_addr && byte_done && !por_active && shift == CHIP_BUS_ADDRESS)
      |=> sda_enable && (state == st_addr_ack))
    else $error("own chip address not acknowledged");

  addr_miss_a: assert property (
    (state == st_addr && byte_done && shift != CHIP_BUS_ADDRESS) |=> !sda_enable [*2])
    else $error("foreign address acknowledged");

  ack_release_a: assert property (
    (sda_enable && scl_fall && !stop_seen && !start_seen) |=> !sda_enable)
    else $error("acknowledge held past its clock");

  no_increment_a: assert property (
    (state == st_data_ack && scl_fall && !start_seen && !stop_seen)
      |=> $stable(sub_sel) && (state == st_data))
    else $error("subaddress advanced between data bytes");

  write_now_a: assert property (
    (data_write && sub_sel == SUB_WAVE_TIMING)
      |=> (waveform_timing_switches == $past(shift)) &&
      (blank_duration_select == $past(shift[BLANK_LEN_POS])))
    else $error("write not applied on the next cycle");

  protect_force_a: assert property (
    protection_trip |=> power_down_bit && !gentle_startup_release)
    else $error("protection did not force start values");

  unmapped_ignore_a: assert property (
    (data_write && !mapped_sub && !protection_trip)
      |=> $stable(blanking_geometry_switches) && $stable(waveform_timing_switches) &&
      $stable(power_startup_switches) && sda_enable)
    else $error("unmapped write altered a register");

  startup_write_a: assert property (
    (data_write && sub_sel == SUB_POWER_STARTUP && !protection_trip)
      |=> gentle_startup_release == $past(shift[STARTUP_POS]))
    else $error("soft start release not taken from data");

  full_write_c: cover property (state == st_data_ack ##[1:1000] state == st_idle);
  repeat_data_c: cover property (data_write ##[1:1000] data_write);
  protect_c: cover property (protection_trip && gentle_startup_release);
  por_nack_c: cover property (byte_done && por_active);

endmodule // deflection_switch_register_port

/* File: verilog/switch_port_pkg.sv */
// Constants shared by the deflection switch register port
package switch_port_pkg;

  // ----------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------
  localparam logic [7:0] CHIP_BUS_ADDRESS = 8'h8C;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_COUNT_STEP = 4'h1;

  // ----------------------------------------------------------------
  // Subaddresses of the switch registers
  // ----------------------------------------------------------------
  localparam logic [7:0] SUB_BLANK_GEOMETRY = 8'h01;
  localparam logic [7:0] SUB_WAVE_TIMING = 8'h0B;
  localparam logic [7:0] SUB_POWER_STARTUP = 8'h0D;

  // ----------------------------------------------------------------
  // Field positions, blanking_geometry_switches
  // ----------------------------------------------------------------
  localparam int UNLOCK_BLANK_POS = 0;
  localparam int PIN_BALANCE_POS = 1;
  localparam int PARALLELOGRAM_POS = 2;
  localparam int GAIN_INHIBIT_POS = 3;
  localparam int LIN_CORNER_POS = 4;
  localparam int MOIRE_POS = 5;
  localparam int TELEVISION_POS = 6;

  // ----------------------------------------------------------------
  // Field positions, waveform_timing_switches
  // ----------------------------------------------------------------
  localparam int EW_TRACK_POS = 0;
  localparam int OVERSCAN_POS = 2;
  localparam int CLAMP_EDGE_POS = 3;
  localparam int BLANK_LEN_POS = 4;
  localparam int LIN_BALANCE_POS = 5;
  localparam int POS_TRAP_POS = 6;
  localparam int SAW_LINK_POS = 7;

  // ----------------------------------------------------------------
  // Field positions and start values, power_startup_switches
  // ----------------------------------------------------------------
  localparam int POWER_DOWN_POS = 0;
  localparam int STARTUP_POS = 1;
  localparam logic POWER_DOWN_START = 1'b1;
  localparam logic STARTUP_START = 1'b0;

  // Defined value for registers whose power-up content is random
  localparam logic [7:0] SWITCH_CLEAR = 8'h00;

  // Receiver states
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_sub,
    st_sub_ack,
    st_data,
    st_data_ack
  } rx_state_t;

endpackage

/* File: verilog/bus_condition_detect.sv */
// Edge, start and stop detection on the serial clock and data lines
`timescale 1ns/1ps
module bus_condition_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic sda_level
);
  logic scl_q;
  logic sda_q;
  logic scl_prev;
  logic sda_prev;

  // Sample lines and keep last value; 250 MHz gives over 600 samples per 400 kHz bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  // Bus conditions: data moving while clock stays high
  assign scl_rise = scl_q && !scl_prev;
  assign scl_fall = !scl_q && scl_prev;
  assign start_seen = scl_q && scl_prev && sda_prev && !sda_q;
  assign stop_seen = scl_q && scl_prev && !sda_prev && sda_q;
  assign sda_level = sda_q;

endmodule // bus_condition_detect

/* File: tb/host_bus_model.sv */
// Serial bus host model that writes the switch port one frame at a time
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull_low
);
  // Clock high time in system clocks; low time adds a quarter of it plus one; the bench may slow it down
  int half_cycles = 8;

  initial begin
    scl = 1'b1;
    sda_pull_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic bus_start();
    sda_pull_low = 1'b0;
    wait_clk(half_cycles / 4 + 1);
    scl = 1'b1;
    wait_clk(half_cycles);
    sda_pull_low = 1'b1;
    wait_clk(half_cycles);
    scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high
  task automatic bus_stop();
    wait_clk(half_cycles / 4 + 1);
    sda_pull_low = 1'b1;
    wait_clk(half_cycles);
    scl = 1'b1;
    wait_clk(half_cycles);
    sda_pull_low = 1'b0;
    wait_clk(half_cycles);
  endtask

  // Whole byte, MSB first; data only moves while the clock is low
  task automatic send_byte(input logic [7:0] value, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      wait_clk(half_cycles / 4 + 1);
      sda_pull_low = ~value[i];
      wait_clk(half_cycles);
      scl = 1'b1;
      wait_clk(half_cycles);
      scl = 1'b0;
    end
    // Release the line so the pull-up shows unless the device acknowledges
    wait_clk(half_cycles / 4 + 1);
    sda_pull_low = 1'b0;
    wait_clk(half_cycles);
    scl = 1'b1;
    wait_clk(half_cycles / 2);
    ack = ~sda_line;
    wait_clk(half_cycles - half_cycles / 2);
    scl = 1'b0;
  endtask
endmodule // host_bus_model

/* File: tb/deflection_switch_register_port_test.sv */
// Self-checking bench for the deflection switch register port
`timescale 1ns/1ps
module deflection_switch_register_port_test;
  import switch_port_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic por_active = 1'b0;
  logic protection_trip = 1'b0;
  logic scl, sda_pull_low, sda_value, sda_enable, sda_line;
  logic ub, pb, pg, gi, lc, mc, tv, ew, os, ce, bd, lb, pt, sl, pd, gs;
  logic [7:0] exp_geo, exp_wave, exp_pwr;
  int bad_count = 0;
  int cmp_count = 0;

  // Open-drain data line with pull-up
  assign sda_line = ~(sda_pull_low | (sda_enable & ~sda_value));

  always #2 clk = ~clk;

  deflection_switch_register_port i_deflection_switch_register_port (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda(sda_line), .sda_value(sda_value),
    .sda_enable(sda_enable), .por_active(por_active), .protection_trip(protection_trip),
    .unlock_blank_exclude(ub), .pin_balance_wave_disable(pb), .parallelogram_wave_disable(pg),
    .oscillator_gain_loop_inhibit(gi), .linearity_corner_centre_force(lc),
    .moire_cancel_disable(mc), .television_fmin_select(tv), .ew_line_tracking(ew),
    .overscan_size_select(os), .clamp_leading_edge(ce), .blank_duration_select(bd),
    .linearity_balance_centre_force(lb), .position_trapezium_centre_force(pt),
    .sawtooth_link_connect(sl), .power_down_bit(pd), .gentle_startup_release(gs)
  );

  host_bus_model i_host_bus_model (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull_low(sda_pull_low)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] expv, input string what);
    cmp_count++;
    if (seen !== expv) begin
      bad_count++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  // Compare every switch output with the expected register images
  task automatic check_regs();
    check({4'h0, gi, pg, pb, ub}, {4'h0, exp_geo[3:0]}, "01 lo");
    check({5'h00, tv, mc, lc}, {5'h00, exp_geo[6:4]}, "01 hi");
    check({6'h00, os, ew}, {6'h00, exp_wave[2], exp_wave[0]}, "0B lo");
    check({6'h00, bd, ce}, {6'h00, exp_wave[4:3]}, "0B mid");
    check({5'h00, sl, pt, lb}, {5'h00, exp_wave[7:5]}, "0B hi");
    check({6'h00, gs, pd}, {6'h00, exp_pwr[1:0]}, "sub 0D");
  endtask

  // One frame: address, subaddress, then n data bytes to that subaddress
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] sub, input logic [7:0] d0,
      input logic [7:0] d1, input int n, input logic exp_ack);
    logic ack;
    logic [7:0] d;
    i_host_bus_model.bus_start();
    i_host_bus_model.send_byte(addr, ack);
    check({7'h00, ack}, {7'h00, exp_ack}, "address ack");
    if (exp_ack === 1'b1) begin
      i_host_bus_model.send_byte(sub, ack);
      check({7'h00, ack}, 8'h01, "subaddress ack");
      for (int k = 0; k < n; k++) begin
        d = (k == 0) ? d0 : d1;
        i_host_bus_model.send_byte(d, ack);
        check({7'h00, ack}, 8'h01, "data ack");
        if (sub === SUB_BLANK_GEOMETRY) exp_geo = d;
        if (sub === SUB_WAVE_TIMING) exp_wave = d;
        if (sub === SUB_POWER_STARTUP && protection_trip !== 1'b1) exp_pwr = d;
        check_regs();
      end
    end
    i_host_bus_model.bus_stop();
    check_regs();
  endtask

  task automatic t_reset();
    check({7'h00, sda_enable}, 8'h00, "idle ack");
    check({7'h00, sda_value}, 8'h00, "drive level");
    check_regs();
    $display("test reset done");
  endtask

  task automatic t_power_on_refusal();
    por_active = 1'b1;
    write_reg(CHIP_BUS_ADDRESS, SUB_BLANK_GEOMETRY, 8'h7F, 8'h00, 1, 1'b0);
    por_active = 1'b0;
    $display("test power-on refusal done");
  endtask

  // Full bytes to every register, soft start released last
  task automatic t_preset();
    write_reg(CHIP_BUS_ADDRESS, SUB_BLANK_GEOMETRY, 8'h00, 8'h00, 1, 1'b1);
    write_reg(CHIP_BUS_ADDRESS, SUB_WAVE_TIMING, 8'h00, 8'h00, 1, 1'b1);
    write_reg(CHIP_BUS_ADDRESS, SUB_POWER_STARTUP, 8'h00, 8'h00, 1, 1'b1);
    write_reg(CHIP_BUS_ADDRESS, SUB_POWER_STARTUP, 8'h02, 8'h00, 1, 1'b1);
    $display("test preset done");
  endtask

  // Walking one, all ones and all zeros through each switch register
  task automatic t_walk_bits();
    logic [7:0] subs [3];
    logic [7:0] v;
    subs = '{SUB_BLANK_GEOMETRY, SUB_WAVE_TIMING, SUB_POWER_STARTUP};
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 10; i++) begin
        v = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'hFF : 8'h00);
        write_reg(CHIP_BUS_ADDRESS, subs[s], v, 8'h00, 1, 1'b1);
      end
    end
    $display("test walking bits done");
  endtask

  task automatic t_same_target();
    write_reg(CHIP_BUS_ADDRESS, SUB_BLANK_GEOMETRY, 8'h55, 8'h2A, 2, 1'b1);
    write_reg(CHIP_BUS_ADDRESS, SUB_WAVE_TIMING, 8'hFF, 8'h00, 2, 1'b1);
    $display("test no increment done");
  endtask

  task automatic t_unmapped();
    write_reg(CHIP_BUS_ADDRESS, 8'h02, 8'hFF, 8'h00, 1, 1'b1);
    write_reg(CHIP_BUS_ADDRESS, 8'h0E, 8'hFF, 8'h00, 1, 1'b1);
    write_reg(CHIP_BUS_ADDRESS | 8'h01, SUB_BLANK_GEOMETRY, 8'hFF, 8'h00, 1, 1'b0);
    write_reg(8'h8E, SUB_BLANK_GEOMETRY, 8'hFF, 8'h00, 1, 1'b0);
    $display("test unmapped and foreign address done");
  endtask

  // Protection forces the power bits even against a host write
  task automatic t_protection();
    write_reg(CHIP_BUS_ADDRESS, SUB_POWER_STARTUP, 8'h02, 8'h00, 1, 1'b1);
    protection_trip = 1'b1;
    exp_pwr = {6'h00, STARTUP_START, POWER_DOWN_START};
    repeat (2) @(negedge clk);
    check_regs();
    write_reg(CHIP_BUS_ADDRESS, SUB_POWER_STARTUP, 8'h02, 8'h00, 1, 1'b1);
    protection_trip = 1'b0;
    repeat (2) @(negedge clk);
    check_regs();
    $display("test protection done");
  endtask

  // Host clock near 355 kHz: 1.25 us high phase is 313 system clocks, low phase 392
  task automatic t_fast_mode();
    i_host_bus_model.half_cycles = 313;
    write_reg(CHIP_BUS_ADDRESS, SUB_BLANK_GEOMETRY, 8'hA5, 8'h00, 1, 1'b1);
    i_host_bus_model.half_cycles = 8;
    $display("test fast mode done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    exp_geo = SWITCH_CLEAR;
    exp_wave = SWITCH_CLEAR;
    exp_pwr = {6'h00, STARTUP_START, POWER_DOWN_START};
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_power_on_refusal();
    t_preset();
    t_walk_bits();
    t_same_target();
    t_unmapped();
    t_protection();
    t_fast_mode();
    final_report();
  end

  // Watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule // deflection_switch_register_port_test
